/* File: cpu_clk_power.sv */
/*
  Processor clock divider and power-down/wake controller with an APB register
  slave. Assumes CLOCK is an always-on oscillator that keeps running while the
  gated internal clock (PERIPH_CLK_EN) is stopped, and that all wake inputs
  are synchronous to CLOCK.
*/
`timescale 1ns/10ps
module cpu_clk_power import cpu_clk_power_pkg::*; #(
  parameter int WAKE_CYC = WAKE_SETTLE_CYC // Restart settle, cycles
) (
  input wire logic CLOCK, // 50 MHz always-on clock
  input wire logic RESET, // Asynchronous, active high
  input wire logic PSEL, // APB select
  input wire logic PENABLE, // APB access phase
  input wire logic PWRITE, // APB direction
  input wire logic [ADDR_W-1:0] PADDR, // APB byte address
  input wire logic [31:0] PWDATA, // APB write data
  output logic PREADY, // APB ready
  output logic [31:0] PRDATA, // APB read data
  output logic PSLVERR, // APB error on unmapped address
  input wire logic [3:0] USB_LINE, // Port lines 2B,2A,1B,1A
  input wire logic OTG_VBUS_VALID, // OTG bus voltage valid
  input wire logic OTG_ID, // OTG identification
  input wire logic FAST_SERIAL_PORT_RX, // Fast serial receive line
  input wire logic SERIAL_SLAVE_SELECT_LOW, // Slave select, active low
  input wire logic PARALLEL_HOST_PORT_READ, // Host port read strobe
  input wire logic [1:0] GENERAL_INPUT, // General inputs 25:24
  input wire logic BOOSTER_RAIL_OK, // Booster rails at or above 3.0V
  input wire logic IRQ_PENDING, // Any enabled interrupt raised
  output logic CPU_CLK_EN, // Processor clock enable pulse
  output logic PERIPH_CLK_EN, // Internal clock run, freezes counters
  output logic SUPPLY_ON, // Booster, charge pump, transceivers on
  output logic OTG_CHANGE_IRQ_LINE, // OTG change interrupt pulse
  output logic DROP_FAST_SERIAL_BYTE, // Discard byte that woke us
  output logic DROP_SPI_BYTE // Discard byte that woke us
);
  // ==========================================================================
  // State
  typedef struct packed {
    mode_t mode; // Operating mode
    logic [SPEED_W-1:0] spd; // Divider field
    logic [SPEED_W-1:0] div_cnt; // Divider phase
    logic [15:0] pwr; // Stored wake enables
    logic [WAKE_CNT_W-1:0] wake_cnt; // Settle counter
    logic [3:0] usb_q; // Previous port lines
    logic [1:0] otg_q; // Previous vbus valid and id
    logic fsr_q; // Previous serial receive
    logic ss_q; // Previous slave select
    logic [1:0] gpi_q; // Previous general inputs
    logic hist_ok; // Input history valid after first edge
    logic cpu_en; // Output registers follow
    logic periph_en;
    logic supply_on;
    logic otg_irq;
    logic drop_fsr;
    logic drop_ss;
    logic pready;
    logic pslverr;
    logic [15:0] prdata;
  } state_t;

  state_t st_r;
  state_t st_nxt;
  logic setup; // APB setup cycle
  logic access; // APB access edge
  logic wr_spd; // Divider write takes effect
  logic wr_pwr; // Power register write takes effect
  logic [3:0] usb_hit; // Enabled port transitions
  logic otg_chg; // OTG signal changed
  logic fsr_hit;
  logic ss_hit;
  logic gpi_hit;
  logic hpr_hit;
  logic wake_any; // Any enabled wake event

  // Address decode shared by read and write paths
  function automatic logic [1:0] reg_sel(input logic [ADDR_W-1:0] a);
    if (a == SPEED_ADDR) begin
      reg_sel = 2'h1;
    end else if (a == POWER_ADDR) begin
      reg_sel = 2'h2;
    end else begin
      reg_sel = 2'h0;
    end
  endfunction

  // ==========================================================================
  // Bus phases and wake event detection
  assign setup = PSEL && !PENABLE;
  assign access = PSEL && PENABLE && st_r.pready;
  assign wr_spd = access && PWRITE && (reg_sel(PADDR) == 2'h1);
  assign wr_pwr = access && PWRITE && (reg_sel(PADDR) == 2'h2);
  // Edge detection runs on the always-on clock, not the gated one
  assign usb_hit = st_r.pwr[BIT_USB_LO +: 4] & (USB_LINE ^ st_r.usb_q);
  // History is zero after reset; skip the first edge so a high pin is no change
  assign otg_chg = st_r.hist_ok && (|({OTG_VBUS_VALID, OTG_ID} ^ st_r.otg_q));
  assign fsr_hit = st_r.pwr[BIT_FSR] && (FAST_SERIAL_PORT_RX != st_r.fsr_q);
  assign ss_hit = st_r.pwr[BIT_SS] && st_r.ss_q && !SERIAL_SLAVE_SELECT_LOW;
  assign hpr_hit = st_r.pwr[BIT_HPR] && PARALLEL_HOST_PORT_READ;
  assign gpi_hit = st_r.pwr[BIT_GPI] && (|(GENERAL_INPUT ^ st_r.gpi_q));
  assign wake_any = (|usb_hit) || (st_r.pwr[BIT_OTG] && otg_chg) || fsr_hit
                    || ss_hit || hpr_hit || gpi_hit;

  // ==========================================================================
  // Next-state logic
  always_comb begin
    st_nxt = st_r;
    // Input history, sampled every cycle so a stale edge never wakes us
    st_nxt.usb_q = USB_LINE;
    st_nxt.otg_q = {OTG_VBUS_VALID, OTG_ID};
    st_nxt.fsr_q = FAST_SERIAL_PORT_RX;
    st_nxt.ss_q = SERIAL_SLAVE_SELECT_LOW;
    st_nxt.gpi_q = GENERAL_INPUT;
    st_nxt.hist_ok = 1'b1;
    // OTG change line pulses on every change; port wakes raise nothing
    st_nxt.otg_irq = otg_chg;
    st_nxt.drop_fsr = 1'b0;
    st_nxt.drop_ss = 1'b0;
    // APB: zero-wait answer, ready in the access phase
    st_nxt.pready = setup;
    st_nxt.pslverr = setup && (reg_sel(PADDR) == 2'h0);
    st_nxt.prdata = 16'h0000;
    if (setup) begin
      case (reg_sel(PADDR))
        2'h1: begin
          st_nxt.prdata = {{(16 - SPEED_W){1'b0}}, st_r.spd};
        end
        2'h2: begin
          st_nxt.prdata = st_r.pwr & WAKE_MASK;
          st_nxt.prdata[BIT_BOOST] = !BOOSTER_RAIL_OK; // Inverted health
          st_nxt.prdata[BIT_SLEEP] = (st_r.mode == MODE_SLEEP);
          st_nxt.prdata[BIT_HALT] = (st_r.mode == MODE_HALT);
        end
        default: begin
          st_nxt.prdata = 16'h0000;
        end
      endcase
    end
    // Only the divider field and the wake enables are stored; other bits are dropped
    if (wr_spd) begin
      st_nxt.spd = PWDATA[SPEED_W-1:0];
    end
    if (wr_pwr) begin
      st_nxt.pwr = PWDATA[15:0] & WAKE_MASK;
    end
    // Mode sequencing
    case (st_r.mode)
      MODE_RUN: begin
        // Writing zero to sleep or halt has no effect
        if (wr_pwr && PWDATA[BIT_SLEEP]) begin
          st_nxt.mode = MODE_SLEEP;
        end else if (wr_pwr && PWDATA[BIT_HALT]) begin
          st_nxt.mode = MODE_HALT;
        end
      end
      MODE_HALT: begin
        // Clocks keep running; only an interrupt brings the processor back
        if (IRQ_PENDING) begin
          st_nxt.mode = MODE_RUN;
        end
      end
      MODE_SLEEP: begin
        if (wake_any) begin
          st_nxt.mode = MODE_WAKE;
          st_nxt.wake_cnt = '0;
          // The byte in flight is lost while the processor restarts
          st_nxt.drop_fsr = fsr_hit;
          st_nxt.drop_ss = ss_hit;
        end
      end
      MODE_WAKE: begin
        // Settle time stands in for supply and oscillator restart
        if (st_r.wake_cnt >= WAKE_CNT_W'(WAKE_CYC - 1)) begin
          st_nxt.mode = MODE_RUN;
        end else begin
          st_nxt.wake_cnt = st_r.wake_cnt + 1'b1;
        end
      end
      default: begin
        st_nxt.mode = MODE_RUN;
      end
    endcase
    // Processor divider: one enable per spd+1 system clocks
    // Judged on the next mode so no enable leaks into a sleep or halt cycle
    st_nxt.cpu_en = 1'b0;
    if (st_nxt.mode == MODE_RUN) begin
      if (st_r.div_cnt >= st_r.spd) begin
        st_nxt.div_cnt = '0;
        st_nxt.cpu_en = 1'b1;
      end else begin
        st_nxt.div_cnt = st_r.div_cnt + 4'h1;
      end
    end else begin
      st_nxt.div_cnt = '0; // Restart phase cleanly after halt or sleep
    end
    // Gated clock and supplies; divisor never touches peripherals
    st_nxt.periph_en = (st_nxt.mode != MODE_SLEEP);
    st_nxt.supply_on = (st_nxt.mode != MODE_SLEEP);
  end

  // ==========================================================================
  // State register
  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      st_r <= '{mode: MODE_RUN, spd: SPEED_RST, pwr: POWER_RST,
                periph_en: 1'b1, supply_on: 1'b1, default: '0};
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from the state register
  assign PREADY = st_r.pready;
  assign PRDATA = {16'h0000, st_r.prdata};
  assign PSLVERR = st_r.pslverr;
  assign CPU_CLK_EN = st_r.cpu_en;
  assign PERIPH_CLK_EN = st_r.periph_en;
  assign SUPPLY_ON = st_r.supply_on;
  assign OTG_CHANGE_IRQ_LINE = st_r.otg_irq;
  assign DROP_FAST_SERIAL_BYTE = st_r.drop_fsr;
  assign DROP_SPI_BYTE = st_r.drop_ss;

  // ==========================================================================
  // Assertions
  localparam int WAKE_LIM = WAKE_MAX_CYC;

  property p_div_due;
    @(posedge CLOCK) disable iff (RESET)
    (st_r.mode == MODE_RUN && st_r.div_cnt >= st_r.spd
     && !(wr_pwr && (PWDATA[BIT_SLEEP] || PWDATA[BIT_HALT]))) |=> CPU_CLK_EN;
  endproperty
  a_div_due: assert property (p_div_due) else $error("divider enable missed");

  property p_div_gap;
    @(posedge CLOCK) disable iff (RESET)
    (CPU_CLK_EN && st_r.spd == 4'h1 && st_r.mode == MODE_RUN) |=> !CPU_CLK_EN;
  endproperty
  a_div_gap: assert property (p_div_gap) else $error("divider too fast");

  property p_periph_full;
    @(posedge CLOCK) disable iff (RESET)
    ((st_r.mode == MODE_RUN && !(wr_pwr && PWDATA[BIT_SLEEP])) || st_r.mode == MODE_HALT)
    |=> PERIPH_CLK_EN;
  endproperty
  a_periph_full: assert property (p_periph_full) else $error("peripheral clock gated");

  property p_sleep_enter;
    @(posedge CLOCK) disable iff (RESET)
    (st_r.mode == MODE_RUN && wr_pwr && PWDATA[BIT_SLEEP]) |=> st_r.mode == MODE_SLEEP;
  endproperty
  a_sleep_enter: assert property (p_sleep_enter) else $error("sleep not entered");

  property p_sleep_off;
    @(posedge CLOCK) disable iff (RESET)
    (st_r.mode == MODE_SLEEP) |-> (!PERIPH_CLK_EN && !SUPPLY_ON && !CPU_CLK_EN);
  endproperty
  a_sleep_off: assert property (p_sleep_off) else $error("clock or supply on in sleep");

  property p_usb_wake;
    @(posedge CLOCK) disable iff (RESET)
    (st_r.mode == MODE_SLEEP && |usb_hit) |=> st_r.mode == MODE_WAKE;
  endproperty
  a_usb_wake: assert property (p_usb_wake) else $error("port wake missed");

  property p_ss_drop;
    @(posedge CLOCK) disable iff (RESET)
    (st_r.mode == MODE_SLEEP && ss_hit) |=> DROP_SPI_BYTE ##1 !DROP_SPI_BYTE;
  endproperty
  a_ss_drop: assert property (p_ss_drop) else $error("slave select byte not dropped");

  property p_fsr_drop;
    @(posedge CLOCK) disable iff (RESET)
    (st_r.mode == MODE_SLEEP && fsr_hit) |=> DROP_FAST_SERIAL_BYTE;
  endproperty
  a_fsr_drop: assert property (p_fsr_drop) else $error("serial byte not dropped");

  property p_otg_line;
    @(posedge CLOCK) disable iff (RESET)
    ($changed(OTG_ID) && !$past(RESET)) |=> OTG_CHANGE_IRQ_LINE;
  endproperty
  a_otg_line: assert property (p_otg_line) else $error("otg line not raised");

  property p_boost_read;
    @(posedge CLOCK) disable iff (RESET)
    (setup && reg_sel(PADDR) == 2'h2) |=> PRDATA[BIT_BOOST] == !$past(BOOSTER_RAIL_OK);
  endproperty
  a_boost_read: assert property (p_boost_read) else $error("booster status wrong");

  property p_wake_bound;
    @(posedge CLOCK) disable iff (RESET)
    (st_r.mode == MODE_WAKE) |-> st_r.wake_cnt < WAKE_LIM;
  endproperty
  a_wake_bound: assert property (p_wake_bound) else $error("resume too slow");

  property p_halt_exit;
    @(posedge CLOCK) disable iff (RESET)
    (st_r.mode == MODE_HALT && IRQ_PENDING) |=> st_r.mode == MODE_RUN ##1 PERIPH_CLK_EN;
  endproperty
  a_halt_exit: assert property (p_halt_exit) else $error("halt not left");

  c_sleep_wake: cover property (@(posedge CLOCK) disable iff (RESET)
    st_r.mode == MODE_SLEEP ##1 st_r.mode == MODE_WAKE);
  c_wake_run: cover property (@(posedge CLOCK) disable iff (RESET)
    st_r.mode == MODE_WAKE ##1 st_r.mode == MODE_RUN);
  c_halt_run: cover property (@(posedge CLOCK) disable iff (RESET)
    st_r.mode == MODE_HALT ##1 st_r.mode == MODE_RUN);
endmodule

/* File: cpu_clk_power_pkg.sv */
/*
  Shared constants for the processor clock divider and power/wake controller:
  register indices, field positions, write masks, reset values, mode codes and
  timing figures. Assumes a 50 MHz always-on clock feeds the controller.
*/
package cpu_clk_power_pkg;
  // ==========================================================================
  // Register map (printed offsets are register indices; byte address = 4x)
  localparam logic [15:0] SPEED_IDX = 16'hc008; // Processor clock divider
  localparam logic [15:0] POWER_IDX = 16'hc00a; // Power and wake control
  localparam int ADDR_W = 18; // Enough for four times the largest index
  localparam logic [ADDR_W-1:0] SPEED_ADDR = ADDR_W'({SPEED_IDX, 2'b00});
  localparam logic [ADDR_W-1:0] POWER_ADDR = ADDR_W'({POWER_IDX, 2'b00});
  // ==========================================================================
  // Field layout
  localparam logic [3:0] SPEED_RST = 4'hf; // Slowest processor clock
  localparam int SPEED_W = 4;
  localparam int BIT_USB_LO = 12; // Ports 1A,1B,2A,2B at bits 12..15
  localparam int BIT_OTG = 11;
  localparam int BIT_FSR = 9; // Fast serial receive wake
  localparam int BIT_SS = 8; // Slave select wake
  localparam int BIT_HPR = 7; // Parallel host port read wake
  localparam int BIT_GPI = 4; // General input wake
  localparam int BIT_BOOST = 2; // Booster rail fail status
  localparam int BIT_SLEEP = 1;
  localparam int BIT_HALT = 0;
  localparam logic [15:0] WAKE_MASK = 16'hfb90; // Stored wake enables
  localparam logic [15:0] POWER_RST = 16'h0000;
  // ==========================================================================
  // Timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int WAKE_MAX_NS = 500000; // Resume bound, 0.5 ms
  localparam int WAKE_MAX_CYC = WAKE_MAX_NS / CLK_PERIOD_NS; // Rounded down
  localparam int WAKE_SETTLE_NS = 300000; // Default restart settle time
  localparam int WAKE_SETTLE_CYC = WAKE_SETTLE_NS / CLK_PERIOD_NS;
  localparam int WAKE_CNT_W = 15;
  // ==========================================================================
  // Operating modes
  typedef enum logic [1:0] {
    MODE_RUN = 2'b00, // Processor and peripherals running
    MODE_HALT = 2'b01, // Processor stopped, peripherals running
    MODE_SLEEP = 2'b10, // Internal clock stopped, supplies off
    MODE_WAKE = 2'b11 // Clock restarted, processor waiting to settle
  } mode_t;
endpackage

/* File: cpu_clk_power_tb.sv */
/*
  Self-checking testbench for the processor clock divider and power/wake
  controller. Assumes the package constants, an always-on 20 ns CLOCK and
  a zero-wait APB slave; the restart settle count is shrunk to keep runs short.
*/
`timescale 1ns/10ps
module cpu_clk_power_tb import cpu_clk_power_pkg::*;;
  // ==========================================================================
  // Signals
  localparam int WCYC = 8; // Short settle count, well under the resume bound
  typedef struct {logic [ADDR_W-1:0] a; logic [31:0] w; logic [31:0] r; logic e;} row_t;
  logic clock = 1'b0; // System clock
  logic reset = 1'b1; // Held high at start
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0; // APB controls
  logic [ADDR_W-1:0] paddr = '0; // APB address
  logic [31:0] pwdata = '0; // APB write data
  logic pready, pslverr; // APB answer
  logic [31:0] prdata; // APB read data
  logic [3:0] usb_line = 4'h0; // Port lines
  logic otg_vbus_valid = 1'b0, otg_id = 1'b0; // OTG levels
  logic fsr = 1'b0, ss_low = 1'b1, hpr = 1'b0; // Serial, select, host read
  logic [1:0] gen_in = 2'h0; // General inputs
  logic boost_ok = 1'b1, irq_pending = 1'b0; // Rail status, interrupt
  logic cpu_clk_en, periph_clk_en, supply_on, otg_irq, drop_fs, drop_spi; // Outputs
  int mismatches = 0; // Failed comparisons
  int n_compared = 0; // All comparisons
  logic [31:0] rd; // Scratch read data
  logic er; // Scratch error flag
  int n; // Scratch cycle count
  // Wake enable per source: ports 1A..2B, OTG, fast serial, select, host read, inputs
  localparam logic [15:0] WBIT [9] = '{16'h1000, 16'h2000, 16'h4000, 16'h8000,
    16'h0800, 16'h0200, 16'h0100, 16'h0080, 16'h0010};
  row_t rows [7]; // Write/read cases
  cpu_clk_power #(.WAKE_CYC(WCYC)) i_dut (.CLOCK(clock), .RESET(reset), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PREADY(pready),
    .PRDATA(prdata), .PSLVERR(pslverr), .USB_LINE(usb_line), .OTG_VBUS_VALID(otg_vbus_valid),
    .OTG_ID(otg_id), .FAST_SERIAL_PORT_RX(fsr), .SERIAL_SLAVE_SELECT_LOW(ss_low),
    .PARALLEL_HOST_PORT_READ(hpr), .GENERAL_INPUT(gen_in), .BOOSTER_RAIL_OK(boost_ok),
    .IRQ_PENDING(irq_pending), .CPU_CLK_EN(cpu_clk_en), .PERIPH_CLK_EN(periph_clk_en),
    .SUPPLY_ON(supply_on), .OTG_CHANGE_IRQ_LINE(otg_irq), .DROP_FAST_SERIAL_BYTE(drop_fs),
    .DROP_SPI_BYTE(drop_spi));
  // ==========================================================================
  // Clock and shared tasks
  always #(CLK_PERIOD_NS / 2) clock = ~clock;
  // Compare and count; four-state equality so unknowns never match
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %0t %s: saw %h expected %h", $time, what, seen, exp);
    end
  endtask
  // One APB transfer; starts on the next edge so a release never collides with a new setup
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d,
      output logic [31:0] r, output logic e);
    int k;
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clock);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) chk(32'h0, 32'h1, "no ready");
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Count edges until the processor enable is seen, up to a limit
  task automatic wait_cpu(input int lim, output int k);
    k = 0;
    do begin
      @(posedge clock);
      k++;
    end while (cpu_clk_en !== 1'b1 && k < lim);
  endtask
  // Sleep with one source enabled, try a disabled one, then wake by source s
  task automatic wake(input int s);
    apb(1'b1, POWER_ADDR, {16'h0, WBIT[s] | 16'h0003}, rd, er); // Sleep beats halt
    #1;
    chk(32'(periph_clk_en), 32'h0, "clock not stopped");
    chk(32'(supply_on), 32'h0, "supplies not off");
    chk(32'(cpu_clk_en), 32'h0, "processor clock in sleep");
    @(posedge clock);
    if (s == 8) usb_line[3] <= ~usb_line[3];
    else gen_in[1] <= ~gen_in[1];
    repeat (3) @(posedge clock);
    #1;
    chk(32'(periph_clk_en), 32'h0, "woke on disabled source");
    chk(32'(cpu_clk_en), 32'h0, "processor ran in sleep");
    @(posedge clock);
    case (s)
      0, 1, 2, 3: usb_line[s] <= ~usb_line[s];
      4: otg_id <= ~otg_id;
      5: fsr <= ~fsr;
      6: ss_low <= 1'b0;
      7: hpr <= 1'b1;
      default: gen_in[0] <= ~gen_in[0];
    endcase
    @(posedge clock);
    hpr <= 1'b0;
    ss_low <= 1'b1;
    #1;
    chk(32'(periph_clk_en), 32'h1, "no wake");
    chk(32'(supply_on), 32'h1, "supplies still off");
    chk(32'(otg_irq), 32'(s == 4), "otg interrupt line");
    chk(32'(drop_fs), 32'(s == 5), "serial byte drop");
    chk(32'(drop_spi), 32'(s == 6), "select byte drop");
    wait_cpu(100, n);
    chk(32'(n >= WCYC && n <= WCYC + 3), 32'h1, "resume time");
  endtask
  // Verdict and end of run, shared with the watchdog
  task automatic end_sim;
    if (mismatches == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // ==========================================================================
  // Watchdog: whole run is a few hundred cycles
  initial begin
    repeat (20000) @(posedge clock);
    mismatches++;
    $display("[FAIL] %0t timeout", $time);
    end_sim;
  end
  // ==========================================================================
  // Main sequence
  initial begin
    // Writes keep every reserved bit at zero; unmapped words answer with an error
    rows = '{'{SPEED_ADDR, 32'h7, 32'h7, 1'b0}, '{SPEED_ADDR, 32'h0, 32'h0, 1'b0},
      '{SPEED_ADDR, 32'hf, 32'hf, 1'b0}, '{POWER_ADDR, 32'hfb90, 32'hfb90, 1'b0},
      '{POWER_ADDR, 32'h0, 32'h0, 1'b0}, '{SPEED_ADDR + 18'h4, 32'h1, 32'h0, 1'b1},
      '{POWER_ADDR + 18'h4, 32'h5, 32'h0, 1'b1}};
    repeat (16) @(posedge clock);
    #1;
    chk(32'({periph_clk_en, supply_on, cpu_clk_en}), 32'h6, "reset outputs");
    @(posedge clock);
    reset <= 1'b0;
    apb(1'b0, SPEED_ADDR, 32'h0, rd, er);
    chk(rd, 32'hf, "speed reset value");
    apb(1'b0, POWER_ADDR, 32'h0, rd, er);
    chk(rd, 32'h0, "power reset value");
    // Table of writes with read-back and unmapped addresses
    foreach (rows[i]) begin
      apb(1'b1, rows[i].a, rows[i].w, rd, er);
      chk(32'(er), 32'(rows[i].e), "write error flag");
      apb(1'b0, rows[i].a, 32'h0, rd, er);
      chk(rd, rows[i].r, "read back");
      chk(32'(er), 32'(rows[i].e), "read error flag");
    end
    // Every divider code: enable spacing is code plus one
    for (int k = 0; k < 16; k++) begin
      apb(1'b1, SPEED_ADDR, 32'(k), rd, er);
      wait_cpu(40, n);
      wait_cpu(40, n);
      chk(32'(n), 32'(k + 1), "divider period");
      chk(32'(periph_clk_en), 32'h1, "peripheral clock");
    end
    // Each wake source at full speed
    apb(1'b1, SPEED_ADDR, 32'h0, rd, er);
    for (int s = 0; s < 9; s++) wake(s);
    // Halt stops only the processor until an interrupt
    apb(1'b1, POWER_ADDR, 32'h1, rd, er);
    apb(1'b0, POWER_ADDR, 32'h0, rd, er);
    chk(rd, 32'h1, "halt mode read");
    wait_cpu(20, n);
    chk(32'(n), 32'd20, "processor ran in halt");
    chk(32'(periph_clk_en & supply_on), 32'h1, "halt stopped peripherals");
    irq_pending <= 1'b1;
    @(posedge clock);
    irq_pending <= 1'b0;
    wait_cpu(20, n);
    chk(32'(n <= 3), 32'h1, "halt exit");
    // Booster status reads inverted
    boost_ok <= 1'b0;
    apb(1'b0, POWER_ADDR, 32'h0, rd, er);
    chk(rd, 32'h4, "booster fail status");
    boost_ok <= 1'b1;
    // Reset in mid-sleep restores clocks and register defaults
    apb(1'b1, SPEED_ADDR, 32'h3, rd, er);
    apb(1'b1, POWER_ADDR, 32'h2, rd, er);
    @(posedge clock);
    reset <= 1'b1;
    @(posedge clock);
    #1;
    chk(32'({periph_clk_en, supply_on}), 32'h3, "reset leaves sleep");
    @(posedge clock);
    reset <= 1'b0;
    // OTG id was left high; the first edge after release must not look like a change
    @(posedge clock);
    #1;
    chk(32'(otg_irq), 32'h0, "otg change after reset");
    apb(1'b0, SPEED_ADDR, 32'h0, rd, er);
    chk(rd, 32'hf, "speed after reset");
    apb(1'b0, POWER_ADDR, 32'h0, rd, er);
    chk(rd, 32'h0, "power after reset");
    end_sim;
  end
endmodule
